// File: rfc_pkg.sv
// Constants and types shared by the resistance-to-frequency converter control block
package rfc_pkg;

	// Register indices; the byte address of each is four times its index
	localparam logic [15:0] IDX_CONV_CONFIG   = 16'hff90;
	localparam logic [15:0] IDX_RUN_STATUS    = 16'hff91;
	localparam logic [15:0] IDX_MEAS_NIBBLE0  = 16'hff92;
	localparam logic [15:0] IDX_MEAS_NIBBLE1  = 16'hff93;
	localparam logic [15:0] IDX_IRQ_STATUS    = 16'hffa0;
	localparam logic [15:0] IDX_IRQ_MASK      = 16'hffa1;

	// Bus geometry
	localparam int          AXI_ADDR_W        = 18;
	localparam int          AXI_DATA_W        = 32;
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;

	// conversion_config field positions
	localparam int          CFG_CH_SEL_BIT    = 0;
	localparam int          CFG_TYPE_SEL_BIT  = 1;
	localparam int          CFG_CLK_SEL_BIT   = 2;

	// conversion_run_status field positions
	localparam int          RS_SENS_RUN_BIT   = 0;
	localparam int          RS_REF_RUN_BIT    = 1;
	localparam int          RS_MEAS_OVF_BIT   = 2;
	localparam int          RS_TB_OVF_BIT     = 3;

	// Interrupt status and mask field positions
	localparam int          IRQ_TB_OVF_BIT    = 0;
	localparam int          IRQ_MEAS_OVF_BIT  = 1;
	localparam int          IRQ_RUN_END_BIT   = 2;
	localparam int          IRQ_W             = 3;

	// Reset values
	localparam logic [2:0]  IRQ_RESET         = 3'h0;
	localparam logic [3:0]  NIBBLE_RESET      = 4'h0;

	// Counter widths
	localparam int          MEAS_CNT_W        = 20;
	localparam int          TB_CNT_W          = 20;
	localparam int          NIBBLE_W          = 4;

	// Conversion setup bits
	typedef struct packed {
		logic conv_clock_select;
		logic ch1_sensor_type_select;
		logic conv_channel_select;
	} rfc_cfg_t;

	// Run and overflow state
	typedef struct packed {
		logic timebase_overflow_flag;
		logic measure_overflow_flag;
		logic reference_osc_run;
		logic sensor_osc_run;
	} rfc_run_t;

	// Interrupt events, one bit each
	typedef struct packed {
		logic run_end;
		logic meas_ovf;
		logic tb_ovf;
	} rfc_evt_t;

endpackage

// File: rfc_pin_sync.sv
// Three-stage pin synchroniser with qualified rising-edge pulse
`timescale 1ns/100ps

module rfc_pin_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Pin side
	input  wire logic pin_in,
	// Core side
	output logic      level,
	output logic      rise
);

	logic meta_r;
	logic s2_r;
	logic s3_r;
	logic level_r;

	// The first stage feeds only the second one
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= 1'b0;
			s2_r   <= 1'b0;
			s3_r   <= 1'b0;
		end else begin
			meta_r <= pin_in;
			s2_r   <= meta_r;
			s3_r   <= s2_r;
		end
	end

	// A change counts only once stages two and three agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			level_r <= 1'b0;
		end else if (s2_r == s3_r) begin
			level_r <= s3_r;
		end
	end

	assign level = level_r;
	assign rise  = (s2_r == s3_r) && s3_r && !level_r;

endmodule

// File: rfc_regs.sv
// Control and status registers of the resistance-to-frequency converter
`timescale 1ns/100ps

module rfc_regs
	import rfc_pkg::*;
#(
	parameter int MEAS_W = MEAS_CNT_W,
	parameter int TB_W   = TB_CNT_W
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	// AXI4-Lite write address
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	// AXI4-Lite write response
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	output logic [1:0]                 s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	// AXI4-Lite read data
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic [AXI_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	// Oscillator pins
	input  wire logic                  fast_oscillator,
	input  wire logic                  slow_oscillator,
	input  wire logic                  meas_osc_in,
	// Converter control pins
	output logic                       ref_osc_enable,
	output logic                       sensor_osc_enable,
	output rfc_cfg_t                   conv_cfg,
	// Interrupt
	output logic                       irq
);

	// Bus state
	logic [AXI_ADDR_W-1:0] aw_addr_r;
	logic [AXI_DATA_W-1:0] w_data_r;
	logic [3:0]            w_strb_r;
	logic                  bvalid_r;
	logic [1:0]            bresp_r;
	logic                  rvalid_r;
	logic [AXI_DATA_W-1:0] rdata_r;
	logic [1:0]            rresp_r;

	// Register state
	rfc_cfg_t              cfg_r;
	rfc_run_t              run_r;
	logic [MEAS_W-1:0]     meas_cnt_r;
	logic [TB_W-1:0]       tb_cnt_r;
	logic [IRQ_W-1:0]      irq_stat_r;
	logic [IRQ_W-1:0]      irq_mask_r;
	logic                  irq_r;

	// Derived signals
	logic                  wr_fire;
	logic [15:0]           wr_idx;
	logic                  wr_low_lane;
	logic [3:0]            wr_nib;
	logic                  rd_fire;
	logic [15:0]           rd_idx;
	logic                  fast_rise;
	logic                  slow_rise;
	logic                  osc_rise;
	logic                  tb_tick;
	logic                  running;
	logic                  meas_wrap;
	logic                  tb_wrap;
	logic                  start_ref;
	logic                  start_sens;
	rfc_evt_t              evt;

	// Register index from a byte address
	function automatic logic [15:0] addr_idx(input logic [AXI_ADDR_W-1:0] a);
		return a[AXI_ADDR_W-1:2];
	endfunction

	// True for every index that answers OKAY
	function automatic logic idx_mapped(input logic [15:0] idx);
		return idx == IDX_CONV_CONFIG || idx == IDX_RUN_STATUS ||
			idx == IDX_MEAS_NIBBLE0 || idx == IDX_MEAS_NIBBLE1 ||
			idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK;
	endfunction

	// Pin synchronisers
	rfc_pin_sync u_sync_fast (
		.clk    (clk),
		.arst_n (arst_n),
		.pin_in (fast_oscillator),
		.level  (),
		.rise   (fast_rise)
	);

	rfc_pin_sync u_sync_slow (
		.clk    (clk),
		.arst_n (arst_n),
		.pin_in (slow_oscillator),
		.level  (),
		.rise   (slow_rise)
	);

	rfc_pin_sync u_sync_meas (
		.clk    (clk),
		.arst_n (arst_n),
		.pin_in (meas_osc_in),
		.level  (),
		.rise   (osc_rise)
	);

	// Write path: address and data are taken in either order
	assign wr_fire     = !s_axi_awready && !s_axi_wready && !bvalid_r;
	assign wr_idx      = addr_idx(aw_addr_r);
	assign wr_low_lane = w_strb_r[0];
	assign wr_nib      = w_data_r[NIBBLE_W-1:0];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_awready <= 1'b1;
			aw_addr_r     <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_addr_r     <= s_axi_awaddr;
		end else if (wr_fire) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_wready <= 1'b1;
			w_data_r     <= '0;
			w_strb_r     <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_data_r     <= s_axi_wdata;
			w_strb_r     <= s_axi_wstrb;
		end else if (wr_fire) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r  <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	// Configuration bits steer the counting clock and the pins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_r <= '0;
		end else if (wr_fire && wr_low_lane && wr_idx == IDX_CONV_CONFIG) begin
			cfg_r.conv_clock_select      <= wr_nib[CFG_CLK_SEL_BIT];
			cfg_r.ch1_sensor_type_select <= wr_nib[CFG_TYPE_SEL_BIT];
			cfg_r.conv_channel_select    <= wr_nib[CFG_CH_SEL_BIT];
		end
	end

	// Time base ticks on the selected oscillator
	assign tb_tick = cfg_r.conv_clock_select ? fast_rise : slow_rise;

	// Run control: a zero write is ignored, and only one oscillation runs at a time
	assign running    = run_r.reference_osc_run || run_r.sensor_osc_run;
	assign start_ref  = wr_fire && wr_low_lane && wr_idx == IDX_RUN_STATUS &&
		wr_nib[RS_REF_RUN_BIT] && !running;
	assign start_sens = wr_fire && wr_low_lane && wr_idx == IDX_RUN_STATUS &&
		wr_nib[RS_SENS_RUN_BIT] && !wr_nib[RS_REF_RUN_BIT] && !running;

	// Wrap detection of either counter ends the running oscillation
	assign meas_wrap = running && osc_rise && (&meas_cnt_r);
	assign tb_wrap   = running && tb_tick && (&tb_cnt_r);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_r.reference_osc_run <= 1'b0;
		end else if (start_ref) begin
			run_r.reference_osc_run <= 1'b1;
		end else if (meas_wrap || tb_wrap) begin
			run_r.reference_osc_run <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_r.sensor_osc_run <= 1'b0;
		end else if (start_sens) begin
			run_r.sensor_osc_run <= 1'b1;
		end else if (meas_wrap || tb_wrap) begin
			run_r.sensor_osc_run <= 1'b0;
		end
	end

	// Overflow flags clear when a new run starts; an overflow in that cycle still wins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_r.timebase_overflow_flag <= 1'b0;
		end else if (tb_wrap) begin
			run_r.timebase_overflow_flag <= 1'b1;
		end else if (start_ref || start_sens) begin
			run_r.timebase_overflow_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_r.measure_overflow_flag <= 1'b0;
		end else if (meas_wrap) begin
			run_r.measure_overflow_flag <= 1'b1;
		end else if (start_ref || start_sens) begin
			run_r.measure_overflow_flag <= 1'b0;
		end
	end

	// Counters carry no reset; software loads the two low nibbles of the measure counter before a run
	always_ff @(posedge clk) begin
		if (wr_fire && wr_low_lane && wr_idx == IDX_MEAS_NIBBLE0) begin
			meas_cnt_r[NIBBLE_W-1:0] <= wr_nib;
		end else if (wr_fire && wr_low_lane && wr_idx == IDX_MEAS_NIBBLE1) begin
			meas_cnt_r[2*NIBBLE_W-1:NIBBLE_W] <= wr_nib;
		end else if (running && osc_rise) begin
			meas_cnt_r <= meas_cnt_r + MEAS_W'(1);
		end
	end

	// Time base restarts from zero at each run start
	always_ff @(posedge clk) begin
		if (start_ref || start_sens) begin
			tb_cnt_r <= '0;
		end else if (running && tb_tick) begin
			tb_cnt_r <= tb_cnt_r + TB_W'(1);
		end
	end

	// Interrupt events
	assign evt.tb_ovf   = tb_wrap;
	assign evt.meas_ovf = meas_wrap;
	assign evt.run_end  = meas_wrap || tb_wrap;

	// Sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_r <= IRQ_RESET;
		end else if (wr_fire && wr_low_lane && wr_idx == IDX_IRQ_STATUS) begin
			irq_stat_r <= (irq_stat_r & ~w_data_r[IRQ_W-1:0]) | evt;
		end else begin
			irq_stat_r <= irq_stat_r | evt;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_mask_r <= IRQ_RESET;
		end else if (wr_fire && wr_low_lane && wr_idx == IDX_IRQ_MASK) begin
			irq_mask_r <= w_data_r[IRQ_W-1:0];
		end
	end

	// Registered level; follows masked status one cycle late
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	// Pin outputs are flopped copies of the registers, one cycle behind them
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ref_osc_enable    <= 1'b0;
			sensor_osc_enable <= 1'b0;
			conv_cfg          <= '0;
		end else begin
			ref_osc_enable    <= run_r.reference_osc_run;
			sensor_osc_enable <= run_r.sensor_osc_run;
			conv_cfg          <= cfg_r;
		end
	end

	// Read path: one read at a time, answered the cycle after acceptance
	assign rd_fire = s_axi_arvalid && !rvalid_r;
	assign rd_idx  = addr_idx(s_axi_araddr);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid_r      <= 1'b0;
			s_axi_arready <= 1'b1;
			rdata_r       <= '0;
			rresp_r       <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_r      <= 1'b1;
			s_axi_arready <= 1'b0;
			rresp_r  <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
			rdata_r  <= '0;
			unique case (rd_idx)
				IDX_CONV_CONFIG: begin
					rdata_r[CFG_CLK_SEL_BIT]  <= cfg_r.conv_clock_select;
					rdata_r[CFG_TYPE_SEL_BIT] <= cfg_r.ch1_sensor_type_select;
					rdata_r[CFG_CH_SEL_BIT]   <= cfg_r.conv_channel_select;
				end
				IDX_RUN_STATUS: begin
					rdata_r[RS_TB_OVF_BIT]   <= run_r.timebase_overflow_flag;
					rdata_r[RS_MEAS_OVF_BIT] <= run_r.measure_overflow_flag;
					rdata_r[RS_REF_RUN_BIT]  <= run_r.reference_osc_run;
					rdata_r[RS_SENS_RUN_BIT] <= run_r.sensor_osc_run;
				end
				IDX_MEAS_NIBBLE0: begin
					rdata_r[NIBBLE_W-1:0] <= meas_cnt_r[NIBBLE_W-1:0];
				end
				IDX_MEAS_NIBBLE1: begin
					rdata_r[NIBBLE_W-1:0] <= meas_cnt_r[2*NIBBLE_W-1:NIBBLE_W];
				end
				IDX_IRQ_STATUS: begin
					rdata_r[IRQ_W-1:0] <= irq_stat_r;
				end
				IDX_IRQ_MASK: begin
					rdata_r[IRQ_W-1:0] <= irq_mask_r;
				end
				default: begin
					rdata_r <= '0;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_r      <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign irq           = irq_r;

endmodule

// File: rfc_regs_props.sv
// Assertion checker for the converter control registers
`timescale 1ns/100ps
module rfc_regs_props
	import rfc_pkg::*;
#(
	parameter int MEAS_W = MEAS_CNT_W,
	parameter int TB_W   = TB_CNT_W
) (
	// Clock and reset
	input wire logic                  clk,
	input wire logic                  arst_n,
	// Bus handshakes
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic                  s_axi_wvalid,
	input wire logic                  s_axi_wready,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
	// Converter outputs
	input wire logic                  ref_osc_enable,
	input wire logic                  sensor_osc_enable,
	input wire rfc_cfg_t              conv_cfg
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Outputs copy the registers one cycle late, so a change trails the write answer
	sequence s_wr_done;
		$past(s_axi_bvalid);
	endsequence

	property p_wr_answer; s_wr_both |-> ##2 s_axi_bvalid; endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer not in time");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
	property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer not in time");
	property p_rd_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read answer changed early");
	property p_cfg_by_write; !$stable(conv_cfg) |-> s_wr_done; endproperty
	a_cfg_by_write: assert property (p_cfg_by_write) else $error("config moved alone");
	property p_one_run; !(ref_osc_enable && sensor_osc_enable); endproperty
	a_one_run: assert property (p_one_run) else $error("two oscillations at once");
	property p_ref_start; $rose(ref_osc_enable) |-> s_wr_done; endproperty
	a_ref_start: assert property (p_ref_start) else $error("reference run unasked");
	property p_sens_start; $rose(sensor_osc_enable) |-> s_wr_done; endproperty
	a_sens_start: assert property (p_sens_start) else $error("sensor run unasked");
	property p_sens_min; $rose(sensor_osc_enable) |-> sensor_osc_enable[*3]; endproperty
	a_sens_min: assert property (p_sens_min) else $error("sensor run too short");
endmodule

bind rfc_regs rfc_regs_props #(.MEAS_W(MEAS_W), .TB_W(TB_W)) i_rfc_regs_props (
	.clk(clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.ref_osc_enable(ref_osc_enable), .sensor_osc_enable(sensor_osc_enable), .conv_cfg(conv_cfg)
);

// File: rfc_osc_model.sv
// Behavioural oscillators beyond the converter pins
`timescale 1ns/100ps
module rfc_osc_model #(
	parameter int MEAS_HALF = 12
) (
	// Clock
	input wire logic clk,
	// Run enables
	input wire logic ref_osc_enable,
	input wire logic sensor_osc_enable,
	// Oscillator pins
	output logic     fast_oscillator,
	output logic     slow_oscillator,
	output logic     meas_osc_in
);
	int         meas_cnt = 0;
	logic [4:0] div      = 5'h0;
	// Free running, halves of 4 and 16 cycles so the synchroniser sees every phase
	assign fast_oscillator = div[2];
	assign slow_oscillator = div[4];
	always @(posedge clk) div <= div + 5'h1;
	// The resistor oscillation stands low whenever no run is enabled
	always @(posedge clk) meas_cnt <= (ref_osc_enable || sensor_osc_enable) ? meas_cnt + 1 : 0;
	assign meas_osc_in = ((meas_cnt / MEAS_HALF) % 2) == 1;
endmodule

// File: rfc_regs_test.sv
// Self-checking bench for the converter control registers
`timescale 1ns/100ps
module rfc_regs_test
	import rfc_pkg::*;
;
	localparam logic [17:0] A_CFG = {IDX_CONV_CONFIG, 2'h0};
	localparam logic [17:0] A_RUN = {IDX_RUN_STATUS, 2'h0};
	localparam logic [17:0] A_NB0 = {IDX_MEAS_NIBBLE0, 2'h0};
	localparam logic [17:0] A_NB1 = {IDX_MEAS_NIBBLE1, 2'h0};
	localparam logic [17:0] A_IST = {IDX_IRQ_STATUS, 2'h0};
	localparam logic [17:0] A_IMK = {IDX_IRQ_MASK, 2'h0};
	localparam logic [17:0] A_BAD = 18'h3fffc;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        awv = 1'b0;
	logic        wv = 1'b0;
	logic        br = 1'b0;
	logic        arv = 1'b0;
	logic        rr = 1'b0;
	logic [3:0]  ws = 4'hf;
	logic [17:0] awa = 18'h0;
	logic [17:0] ara = 18'h0;
	logic [31:0] wd = 32'h0;
	logic        awr, wrdy, bv, arr, rv, irq, fast, slow, meas, ref_en, sen_en;
	logic [1:0]  bresp, rresp;
	logic [31:0] rd;
	rfc_cfg_t    cfg;
	int          error_cnt = 0;
	int          samples_checked = 0;
	// Cycles the master lets pass before raising bready or rready
	int          hold_cyc = 0;

	always #5 clk = !clk;

	rfc_regs #(.MEAS_W(8), .TB_W(8)) i_rfc_regs (
		.clk(clk), .arst_n(arst_n),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
		.fast_oscillator(fast), .slow_oscillator(slow), .meas_osc_in(meas),
		.ref_osc_enable(ref_en), .sensor_osc_enable(sen_en), .conv_cfg(cfg), .irq(irq)
	);
	rfc_osc_model i_rfc_osc_model (
		.clk(clk), .ref_osc_enable(ref_en), .sensor_osc_enable(sen_en),
		.fast_oscillator(fast), .slow_oscillator(slow), .meas_osc_in(meas)
	);

	function automatic logic [31:0] bit_of(input int b);
		return 32'h1 << b;
	endfunction
	function automatic logic [31:0] cfg_exp(input logic [31:0] d);
		return {29'h0, d[2:0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// A hang counts as one mismatch and closes the run
	task automatic timed_out();
		check(32'h0, 32'h1);
		tally_and_finish();
	endtask

	// Address and data go out together; each drops at the edge that takes it
	task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		br <= (hold_cyc == 0);
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
			n++;
			if (!br && n >= hold_cyc) br <= 1'b1;
		end while (!(bv && br) && n < 100);
		br <= 1'b0;
		if (n >= 100) timed_out();
		check({30'h0, bresp}, {30'h0, er});
		@(posedge clk);
	endtask
	task automatic rchk(input logic [17:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		arv <= 1'b1;
		ara <= a;
		rr <= (hold_cyc == 0);
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			n++;
			if (!rr && n >= hold_cyc) rr <= 1'b1;
		end while (!(rv && rr) && n < 100);
		rr <= 1'b0;
		if (n >= 100) timed_out();
		check(rd, e);
		check({30'h0, rresp}, {30'h0, er});
		@(posedge clk);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while ((ref_en || sen_en) && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000) timed_out();
		repeat (2) @(posedge clk);
	endtask

	initial begin
		logic [31:0] v;
		void'($urandom(32'h4cfe08e4));
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		check({29'h0, cfg}, 32'h0);
		check({30'h0, ref_en, sen_en}, 32'h0);
		rchk(A_CFG, 32'h0, RESP_OKAY);
		rchk(A_RUN, 32'h0, RESP_OKAY);
		$display("Test reset done");
		for (int i = 0; i < 8; i++) begin
			v = $urandom();
			v[2:0] = i[2:0];
			hold_cyc = $urandom_range(3, 0);
			wr(A_CFG, v, RESP_OKAY);
			check({29'h0, cfg}, cfg_exp(v));
			rchk(A_CFG, cfg_exp(v), RESP_OKAY);
		end
		wr(A_BAD, $urandom(), RESP_SLVERR);
		rchk(A_BAD, 32'h0, RESP_SLVERR);
		// Low byte lane off: answered, but nothing changes
		ws <= 4'he;
		wr(A_CFG, 32'h0, RESP_OKAY);
		ws <= 4'hf;
		check({29'h0, cfg}, cfg_exp(v));
		rchk(A_CFG, cfg_exp(v), RESP_OKAY);
		v = $urandom();
		wr(A_NB0, v, RESP_OKAY);
		wr(A_NB1, v >> 4, RESP_OKAY);
		rchk(A_NB0, {28'h0, v[3:0]}, RESP_OKAY);
		rchk(A_NB1, {28'h0, v[7:4]}, RESP_OKAY);
		hold_cyc = 0;
		$display("Test map done");
		wr(A_CFG, 32'h0, RESP_OKAY);
		wr(A_NB0, 32'he, RESP_OKAY);
		wr(A_NB1, 32'hf, RESP_OKAY);
		wr(A_IMK, 32'h7, RESP_OKAY);
		wr(A_RUN, bit_of(RS_SENS_RUN_BIT), RESP_OKAY);
		check({31'h0, sen_en}, 32'h1);
		wr(A_RUN, 32'h0, RESP_OKAY);
		rchk(A_RUN, bit_of(RS_SENS_RUN_BIT), RESP_OKAY);
		wait_idle();
		rchk(A_RUN, bit_of(RS_MEAS_OVF_BIT), RESP_OKAY);
		rchk(A_IST, bit_of(IRQ_MEAS_OVF_BIT) | bit_of(IRQ_RUN_END_BIT), RESP_OKAY);
		check({31'h0, irq}, 32'h1);
		wr(A_IST, 32'h7, RESP_OKAY);
		check({31'h0, irq}, 32'h0);
		$display("Test sensor run done");
		wr(A_IMK, 32'h0, RESP_OKAY);
		wr(A_CFG, bit_of(CFG_CLK_SEL_BIT), RESP_OKAY);
		wr(A_NB0, 32'h0, RESP_OKAY);
		wr(A_NB1, 32'h0, RESP_OKAY);
		wr(A_RUN, 32'h3, RESP_OKAY);
		check({30'h0, ref_en, sen_en}, 32'h2);
		rchk(A_RUN, bit_of(RS_REF_RUN_BIT), RESP_OKAY);
		wait_idle();
		check({31'h0, irq}, 32'h0);
		rchk(A_RUN, bit_of(RS_TB_OVF_BIT), RESP_OKAY);
		rchk(A_IST, bit_of(IRQ_TB_OVF_BIT) | bit_of(IRQ_RUN_END_BIT), RESP_OKAY);
		wr(A_IMK, 32'h7, RESP_OKAY);
		check({31'h0, irq}, 32'h1);
		wr(A_IST, 32'h7, RESP_OKAY);
		check({31'h0, irq}, 32'h0);
		$display("Test reference run done");
		tally_and_finish();
	end
endmodule
